// >>> verilog/ee_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM link ends
// Assumes: 100 MHz system clock on both ends
// Notes: Times are given in ns, cycle counts derived from them
package ee_pkg;
  localparam int EE_CLK_MHZ = 100;
  // Fixed client code in the upper nibble of the control byte
  localparam logic [3:0] EE_CTRL_CODE = 4'ha;
  localparam logic [2:0] EE_BLOCK_SEL = 3'h0;
  localparam logic [3:0] EE_ACK_SLOT = 4'h8;
  localparam logic [3:0] EE_LAST_BIT = 4'h7;
  localparam logic [7:0] EE_PTR_RST = 8'h00;
  // Spike filter; longest tolerated glitch, rounded down
  localparam int EE_FILT_NS = 50;
  localparam int EE_FILT_CYC = (EE_FILT_NS * EE_CLK_MHZ) / 1000;
  // Internal write cycle length (plain default)
  localparam int EE_WR_TIME_NS = 5000000;
  localparam int EE_WR_CYC = (EE_WR_TIME_NS / 1000) * EE_CLK_MHZ;
  // Host bit timing: one bit is four quarters
  localparam int EE_QTR_NS = 250;
  localparam int EE_QTR_CYC = (EE_QTR_NS * EE_CLK_MHZ + 999) / 1000;
  localparam int EE_FIFO_DEPTH = 8;
  localparam int EE_FIFO_WIDTH = 8;
  typedef enum logic [1:0]
  {
    EE_OP_POLL,
    EE_OP_WRITE,
    EE_OP_CUR_RD,
    EE_OP_RAND_RD
  } ee_op_t;
endpackage

// >>> verilog/ee_bus_if.sv
// Purpose: Two-wire link between host end and EEPROM end
// Assumes: Both lines are open drain with pull-ups
// Notes: An enable high pulls the line to the value (always low)
`timescale 1ns/100ps
interface ee_bus_if;
  logic host_scl_val;
  logic host_scl_en;
  logic host_sda_val;
  logic host_sda_en;
  logic dev_sda_val;
  logic dev_sda_en;
  logic scl;
  logic sda;
  // Wired-AND resolution with pull-up
  assign scl = ~(host_scl_en & ~host_scl_val);
  assign sda = ~((host_sda_en & ~host_sda_val) | (dev_sda_en & ~dev_sda_val));
  modport dev (input scl, input sda, output dev_sda_val, output dev_sda_en);
  modport host (input sda, output host_scl_val, output host_scl_en,
    output host_sda_val, output host_sda_en);
endinterface

// >>> verilog/ee_dev.sv
// Purpose: Client end of the serial EEPROM: ack polling and reads
// Assumes: Link lines are asynchronous; sampled by the 100 MHz clock
// Notes: Data bytes are stored on receipt; busy time follows Stop
// Operation
// - No control byte acknowledge while writing internally
// - Host may poll right after write Stop
// - Poll is Start plus write control byte
// - Acknowledge control byte once write cycle ends
// - Read starts like write, direction bit high
// - Pointer holds last accessed location plus one; after a write the code rolls within the low three bits (0xff gives 0xf8)
// - Acknowledge read address then send eight bits
// - Host no-ack then Stop ends the read
// - Repeated Start after address still loads pointer
// - Host resends control byte with read direction
// - Each host acknowledge sends next consecutive byte
// - Pointer increments after every completed transfer
// - Filter spikes on clock and data inputs
// - Answer only control code 1010, ignore block
// - Word address byte loads the whole pointer
// - Release data line after host no-ack
// - Internal write cycle starts on Stop only
`timescale 1ns/100ps
module ee_dev
  import ee_pkg::*;
#(
  parameter int WR_CYC = EE_WR_CYC,
  parameter int FILT_CYC = EE_FILT_CYC
)
(
  input wire logic clock,
  input wire logic rst_n,
  ee_bus_if.dev bus,
  output logic busy,
  output logic [7:0] ptr
);
  localparam int WCW = $clog2(WR_CYC + 1);

  // Counter widths below only serve these ranges
  if (FILT_CYC < 1 || FILT_CYC > 15)
  begin : g_chk_filt
    $error("ee_dev: FILT_CYC must be 1 to 15");
  end
  if (WR_CYC < 1)
  begin : g_chk_wr
    $error("ee_dev: WR_CYC must be at least 1");
  end

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_CTRL,
    ST_WADR,
    ST_WDAT,
    ST_RDAT,
    ST_IGN
  } ee_dev_state_t;

  // Line fields hold "line is low", so reset zero means an idle bus
  typedef struct packed {
    logic [1:0] lo1;
    logic [1:0] lo2;
    logic [1:0] lof;
    logic [1:0] lop;
    logic [1:0][3:0] fc;
    ee_dev_state_t st;
    logic [3:0] bitc;
    logic skip;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic hack;
    logic wrote;
    logic drv;
    logic [WCW-1:0] wcnt;
  } ee_dev_st_t;

  ee_dev_st_t r;
  ee_dev_st_t nx;
  logic [7:0] mem [0:255];
  logic mem_we;
  logic scl;
  logic sda;
  logic pscl;
  logic psda;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic [7:0] rd_byte;

  // Filtered line levels and bus conditions
  assign scl = ~r.lof[1];
  assign sda = ~r.lof[0];
  assign pscl = ~r.lop[1];
  assign psda = ~r.lop[0];
  assign start = scl & pscl & psda & ~sda;
  assign stop = scl & pscl & ~psda & sda;
  assign rise = scl & ~pscl;
  assign fall = ~scl & pscl;
  assign rd_byte = mem[r.ptr];

  // Next state of the whole client
  always_comb
  begin
    nx = r;
    mem_we = 1'b0;
    nx.lo1 = ~{bus.scl, bus.sda};
    nx.lo2 = r.lo1;
    // Level must differ for FILT_CYC cycles before it is taken
    for (int i = 0; i < 2; i++)
    begin
      if (r.lo2[i] == r.lof[i])
        nx.fc[i] = 4'h0;
      else if (r.fc[i] == 4'(FILT_CYC - 1))
      begin
        nx.lof[i] = r.lo2[i];
        nx.fc[i] = 4'h0;
      end
      else
        nx.fc[i] = r.fc[i] + 4'h1;
    end
    nx.lop = r.lof;
    // Internal write timer; busy while nonzero
    if (r.wcnt != '0)
      nx.wcnt = r.wcnt - WCW'(1);
    if (start)
    begin
      // Also a repeated Start: no write cycle follows, bytes already stored and pointer kept
      nx.st = ST_CTRL;
      nx.bitc = 4'h0;
      nx.skip = 1'b1;
      nx.drv = 1'b0;
      nx.wrote = 1'b0;
    end
    else if (stop)
    begin
      if (r.wrote)
        nx.wcnt = WCW'(WR_CYC);
      nx.wrote = 1'b0;
      nx.st = ST_IDLE;
      nx.drv = 1'b0;
    end
    else if (r.st != ST_IDLE && r.st != ST_IGN)
    begin
      if (rise)
      begin
        if (r.bitc < EE_ACK_SLOT)
          nx.rx = {r.rx[6:0], sda};
        else
          nx.hack = ~sda;
      end
      if (fall)
      begin
        if (r.skip)
          nx.skip = 1'b0;
        else if (r.bitc == EE_LAST_BIT)
        begin
          // Eighth bit done: decide the acknowledge slot
          nx.bitc = EE_ACK_SLOT;
          unique case (r.st)
            ST_CTRL:
            begin
              if (r.rx[7:4] == EE_CTRL_CODE && r.wcnt == '0)
                nx.drv = 1'b1;
              else
                nx.st = ST_IGN;
            end
            ST_WADR:
            begin
              nx.drv = 1'b1;
              nx.ptr = r.rx;
            end
            ST_WDAT:
            begin
              nx.drv = 1'b1;
              mem_we = 1'b1;
              nx.wrote = 1'b1;
              // Page counter rolls within the low three bits
              nx.ptr = {r.ptr[7:3], r.ptr[2:0] + 3'h1};
            end
            ST_RDAT:
              nx.drv = 1'b0;
            default:
              nx.drv = 1'b0;
          endcase
        end
        else if (r.bitc == EE_ACK_SLOT)
        begin
          nx.bitc = 4'h0;
          nx.drv = 1'b0;
          unique case (r.st)
            ST_CTRL:
            begin
              if (r.rx[0])
              begin
                nx.st = ST_RDAT;
                nx.tx = rd_byte;
                nx.ptr = r.ptr + 8'h01;
                nx.drv = ~rd_byte[7];
              end
              else
                nx.st = ST_WADR;
            end
            ST_WADR:
              nx.st = ST_WDAT;
            ST_WDAT:
              nx.st = ST_WDAT;
            ST_RDAT:
            begin
              if (r.hack)
              begin
                nx.tx = rd_byte;
                nx.ptr = r.ptr + 8'h01;
                nx.drv = ~rd_byte[7];
              end
              else
                nx.st = ST_IGN;
            end
            default:
              nx.st = ST_IGN;
          endcase
        end
        else
        begin
          nx.bitc = r.bitc + 4'h1;
          if (r.st == ST_RDAT)
          begin
            nx.tx = {r.tx[6:0], 1'b0};
            nx.drv = ~r.tx[6];
          end
        end
      end
    end
    else
      nx.drv = 1'b0;
  end

  // State register; reset leaves the bus released, pointer at zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= nx;
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge clock)
  begin
    if (mem_we)
      mem[r.ptr] <= r.rx;
  end

  // Open-drain data line: enable means pull low
  assign bus.dev_sda_val = 1'b0;
  assign bus.dev_sda_en = r.drv;
  assign busy = (r.wcnt != '0);
  assign ptr = r.ptr;
endmodule // ee_dev

// >>> verilog/ee_host.sv
// Purpose: Host end: drives clock, polls for ack, reads bytes
// Assumes: No clock stretching by the client
// Notes: Read bytes pass an 8-word FIFO; a full FIFO holds the clock low
`timescale 1ns/100ps
module ee_fifo
#(
  parameter int W = 8,
  parameter int D = 8
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  // Pointer wrap relies on a power-of-two depth
  if (D < 2 || (1 << AW) != D || W < 1)
  begin : g_chk
    $error("ee_fifo: D must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ee_fifo_st_t;

  ee_fifo_st_t r;
  ee_fifo_st_t nx;
  logic push;
  logic pop;

  assign in_ready = (r.cnt != (AW + 1)'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Push and pop may happen in the same cycle
  always_comb
  begin
    nx = r;
    if (push)
    begin
      nx.mem[r.wp] = in_data;
      nx.wp = r.wp + AW'(1);
    end
    if (pop)
      nx.rp = r.rp + AW'(1);
    if (push && !pop)
      nx.cnt = r.cnt + (AW + 1)'(1);
    else if (pop && !push)
      nx.cnt = r.cnt - (AW + 1)'(1);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= nx;
  end
endmodule // ee_fifo

module ee_host
  import ee_pkg::*;
#(
  parameter int QTR_CYC = EE_QTR_CYC,
  parameter int FIFO_D = EE_FIFO_DEPTH
)
(
  input wire logic clock,
  input wire logic rst_n,
  ee_bus_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ee_op_t cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] cmd_len,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack
);
  localparam int QW = $clog2(QTR_CYC + 1);

  if (QTR_CYC < 2)
  begin : g_chk
    $error("ee_host: QTR_CYC must be at least 2");
  end

  typedef enum logic [2:0]
  {
    HS_IDLE,
    HS_START,
    HS_TX,
    HS_RX,
    HS_STOP
  } ee_host_state_t;

  typedef struct packed {
    ee_host_state_t st;
    logic [1:0] q;
    logic [QW-1:0] tcnt;
    logic [3:0] bitc;
    logic [7:0] sh;
    ee_op_t op;
    logic [7:0] adr;
    logic [7:0] dat;
    logic [7:0] len;
    logic [1:0] txk;
    logic rw;
    logic ph2;
    logic s1;
    logic s2;
    logic scl_lo;
    logic sda_lo;
    logic nack;
    logic done;
  } ee_host_st_t;

  ee_host_st_t r;
  ee_host_st_t nx;
  logic tick;
  logic f_valid;
  logic f_ready;

  assign tick = (r.tcnt == QW'(QTR_CYC - 1));
  // Ack slot of a read byte waits here until the FIFO has room
  assign f_valid = (r.st == HS_RX) && (r.q == 2'h0) && (r.bitc == EE_ACK_SLOT);

  // Quarter-bit sequencer
  always_comb
  begin
    nx = r;
    nx.done = 1'b0;
    nx.s1 = bus.sda;
    nx.s2 = r.s1;
    nx.tcnt = (r.st == HS_IDLE || tick) ? '0 : r.tcnt + QW'(1);
    if (r.st == HS_IDLE)
    begin
      if (cmd_valid)
      begin
        nx.st = HS_START;
        nx.op = cmd_op;
        nx.adr = cmd_addr;
        nx.dat = cmd_data;
        nx.len = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
        nx.rw = (cmd_op == EE_OP_CUR_RD);
        nx.ph2 = 1'b0;
        nx.nack = 1'b0;
        nx.q = 2'h0;
      end
    end
    else if (f_valid)
    begin
      // Stall with clock low until the byte is taken
      if (f_ready)
      begin
        nx.sda_lo = (r.len != 8'h01);
        nx.q = 2'h1;
        nx.tcnt = '0;
      end
    end
    else if (tick)
    begin
      nx.q = r.q + 2'h1;
      unique case (r.st)
        HS_START:
        begin
          // Works from idle and as a repeated Start
          unique case (r.q)
            2'h0: nx.sda_lo = 1'b0;
            2'h1: nx.scl_lo = 1'b0;
            2'h2: nx.sda_lo = 1'b1;
            2'h3:
            begin
              nx.scl_lo = 1'b1;
              nx.st = HS_TX;
              nx.sh = {EE_CTRL_CODE, EE_BLOCK_SEL, r.rw};
              nx.bitc = 4'h0;
              nx.txk = 2'h0;
            end
          endcase
        end
        HS_TX:
        begin
          unique case (r.q)
            2'h0: nx.sda_lo = (r.bitc < EE_ACK_SLOT) ? ~r.sh[7] : 1'b0;
            2'h1: nx.scl_lo = 1'b0;
            2'h2: if (r.bitc == EE_ACK_SLOT) nx.nack = r.s2;
            2'h3:
            begin
              nx.scl_lo = 1'b1;
              nx.bitc = r.bitc + 4'h1;
              nx.sh = {r.sh[6:0], 1'b0};
              if (r.bitc == EE_ACK_SLOT)
              begin
                nx.bitc = 4'h0;
                if (r.nack)
                  nx.st = HS_STOP;
                else if (r.txk == 2'h0)
                begin
                  if (r.rw)
                    nx.st = HS_RX;
                  else if (r.op == EE_OP_POLL)
                    nx.st = HS_STOP;
                  else
                  begin
                    nx.sh = r.adr;
                    nx.txk = 2'h1;
                  end
                end
                else if (r.txk == 2'h1 && r.op == EE_OP_RAND_RD)
                begin
                  nx.st = HS_START;
                  nx.ph2 = 1'b1;
                  nx.rw = 1'b1;
                end
                else if (r.txk == 2'h1)
                begin
                  nx.sh = r.dat;
                  nx.txk = 2'h2;
                end
                else
                  nx.st = HS_STOP;
              end
            end
          endcase
        end
        HS_RX:
        begin
          unique case (r.q)
            2'h0: nx.sda_lo = 1'b0;
            2'h1: nx.scl_lo = 1'b0;
            2'h2: if (r.bitc < EE_ACK_SLOT) nx.sh = {r.sh[6:0], r.s2};
            2'h3:
            begin
              nx.scl_lo = 1'b1;
              nx.bitc = r.bitc + 4'h1;
              if (r.bitc == EE_ACK_SLOT)
              begin
                nx.bitc = 4'h0;
                nx.len = r.len - 8'h01;
                if (r.len == 8'h01)
                  nx.st = HS_STOP;
              end
            end
          endcase
        end
        HS_STOP:
        begin
          unique case (r.q)
            2'h0: nx.sda_lo = 1'b1;
            2'h1: nx.scl_lo = 1'b0;
            2'h2: nx.sda_lo = 1'b0;
            2'h3:
            begin
              // Poll may follow at once; no wait is imposed
              nx.st = HS_IDLE;
              nx.done = 1'b1;
            end
          endcase
        end
        default:
          nx.st = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= nx;
  end

  // Read data buffer toward the user side
  ee_fifo #(.W(EE_FIFO_WIDTH), .D(FIFO_D)) u_fifo
  (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(r.sh),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign cmd_ready = (r.st == HS_IDLE);
  assign bus.host_scl_val = 1'b0;
  assign bus.host_scl_en = r.scl_lo;
  assign bus.host_sda_val = 1'b0;
  assign bus.host_sda_en = r.sda_lo;
  assign done = r.done;
  assign nack = r.nack;
endmodule // ee_host

// >>> tb/ee_link_properties.sv
// Purpose: Concurrent checks on the two-wire link between both ends
// Assumes: Both ends run on the one 100 MHz clock
// Notes: Sees resolved wire levels, enables, busy, done and nack
`timescale 1ns/100ps
module ee_link_properties
#(
  parameter int WR_CYC = 3000
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_en,
  input wire logic dev_sda_en,
  input wire logic busy,
  input wire logic done,
  input wire logic nack
);
  logic [15:0] bcnt_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Busy stretch length; exact end slack left to the timer compare
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bcnt_r <= 16'h0;
    else if (busy)
      bcnt_r <= bcnt_r + 16'h1;
    else
      bcnt_r <= 16'h0;
  end
  // Link rules
  AST_NOACK_BUSY: assert property (busy |-> !dev_sda_en)
    else $error("device pulls data line while busy");
  AST_DEV_SDA_SCL_LOW: assert property (
    $changed(dev_sda_en) |-> !scl && !$past(scl, 6))
    else $error("device changes data line outside clock low");
  AST_WRITE_ON_STOP: assert property (
    $rose(busy) |-> scl && $past(scl, 4))
    else $error("write cycle started without a stop");
  AST_START_FRAME: assert property (
    $rose(host_sda_en) && scl |-> ##[20:30] !scl)
    else $error("start not followed by clock low");
  AST_STOP_RELEASE: assert property (
    $fell(host_sda_en) && scl |-> !dev_sda_en [*8])
    else $error("device holds data line after stop");
  AST_BUSY_SPAN: assert property (
    $fell(busy) |-> int'(bcnt_r) >= WR_CYC - 2 && int'(bcnt_r) <= WR_CYC + 2)
    else $error("write cycle length wrong");
  AST_SCL_HIGH_WIDTH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high pulse too short");
  AST_DONE_IDLE: assert property (done |-> scl && sda)
    else $error("done while bus not idle");
  COV_BUSY: cover property ($rose(busy));
  COV_POLL_NACK: cover property (done && nack);
  COV_DEV_DRIVE: cover property ($rose(dev_sda_en));
endmodule // ee_link_properties

// >>> tb/eeprom_read_and_ack_poll_tb.sv
// Purpose: Self-checking bench joining host and EEPROM ends
// Assumes: One 100 MHz clock; second link is bit-banged by the bench
// Notes: Write cycle shortened so the first two polls see busy
`timescale 1ns/100ps
module eeprom_read_and_ack_poll_tb;
  import ee_pkg::*;
  typedef struct {ee_op_t op; logic [7:0] a, n, p;} ee_row_t;
  localparam int WR_CYC = 3000;
  logic clock, rst_n, cmd_valid, cmd_ready, rd_valid, rd_ready;
  logic done, nack, busy, ack2, seen;
  ee_op_t cmd_op;
  logic [7:0] cmd_addr, cmd_data, cmd_len, rd_data, ptr, ptr2, cur;
  int errors, checks_done, i, k, n;
  // Read rows: op, address, length, pointer afterwards
  ee_row_t rows [5] = '{
    '{EE_OP_RAND_RD, 8'hff, 8'h01, 8'h00},
    '{EE_OP_CUR_RD, 8'h00, 8'h01, 8'h01},
    '{EE_OP_RAND_RD, 8'hfe, 8'h04, 8'h02},
    '{EE_OP_RAND_RD, 8'h00, 8'h00, 8'h01},
    '{EE_OP_CUR_RD, 8'h00, 8'h01, 8'h02}};
  ee_bus_if ee_bus_if_i();
  ee_bus_if ee_bus_if_i2();
  ee_host #(.QTR_CYC(EE_QTR_CYC), .FIFO_D(EE_FIFO_DEPTH)) ee_host_i (
    .clock(clock), .rst_n(rst_n), .bus(ee_bus_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_len(cmd_len), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .nack(nack));
  ee_dev #(.WR_CYC(WR_CYC), .FILT_CYC(EE_FILT_CYC)) ee_dev_i (.clock(clock),
    .rst_n(rst_n), .bus(ee_bus_if_i), .busy(busy), .ptr(ptr));
  // Second client faced by a deliberately faulty bench host
  ee_dev #(.WR_CYC(WR_CYC), .FILT_CYC(EE_FILT_CYC)) ee_dev_i2 (.clock(clock),
    .rst_n(rst_n), .bus(ee_bus_if_i2), .busy(), .ptr(ptr2));
  ee_link_properties #(.WR_CYC(WR_CYC)) ee_link_properties_i (.clock(clock),
    .rst_n(rst_n), .scl(ee_bus_if_i.scl), .sda(ee_bus_if_i.sda),
    .host_sda_en(ee_bus_if_i.host_sda_en),
    .dev_sda_en(ee_bus_if_i.dev_sda_en), .busy(busy), .done(done),
    .nack(nack));
  // Stored byte pattern, distinct per address
  function automatic logic [7:0] val(input logic [7:0] a);
    return a ^ 8'h5c;
  endfunction
  task chk(input string s, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, exp, got);
    end
  endtask
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task q;
    repeat (EE_QTR_CYC) @(negedge clock);
  endtask
  // Waits for idle so a command never lands in the refused cycle
  task run_cmd(input ee_op_t op, input logic [7:0] a, input logic [7:0] l);
    int t;
    @(negedge clock);
    for (t = 0; t < 100 && cmd_ready !== 1'b1; t++) @(negedge clock);
    chk("cmd_ready", cmd_ready, 8'h1);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = val(a);
    cmd_len = l;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    for (t = 0; t < 40000 && done !== 1'b1; t++) @(negedge clock);
    chk("cmd_done", done, 8'h1);
  endtask
  task pop(input logic [7:0] exp);
    chk("rd_valid", rd_valid, 8'h1);
    chk("rd_data", rd_data, exp);
    rd_ready = 1'b1;
    @(negedge clock);
    rd_ready = 1'b0;
    // Idle cycle so a following pop never re-raises in the same step
    @(negedge clock);
  endtask
  // Start, one byte MSB first, ack slot, Stop; optional clock spike
  task bb_frame(input logic [7:0] v, input int gbit, output logic acked);
    int b;
    ee_bus_if_i2.host_sda_en = 1'b1;
    q();
    ee_bus_if_i2.host_scl_en = 1'b1;
    for (b = 8; b >= 0; b--)
    begin
      q();
      ee_bus_if_i2.host_sda_en = (b > 0) ? ~v[b-1] : 1'b0;
      if (b == gbit)
      begin
        ee_bus_if_i2.host_scl_en = 1'b0;
        repeat (3) @(negedge clock);
        ee_bus_if_i2.host_scl_en = 1'b1;
      end
      q();
      ee_bus_if_i2.host_scl_en = 1'b0;
      q();
      seen = ee_bus_if_i2.sda;
      q();
      ee_bus_if_i2.host_scl_en = 1'b1;
    end
    acked = ~seen;
    q();
    ee_bus_if_i2.host_sda_en = 1'b1;
    q();
    ee_bus_if_i2.host_scl_en = 1'b0;
    q();
    ee_bus_if_i2.host_sda_en = 1'b0;
    q();
  endtask
  // Free-running system clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Cuts a hang short
  initial
  begin
    repeat (100000) @(posedge clock);
    errors++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {rst_n, cmd_valid, rd_ready} = 3'b000;
    cmd_op = EE_OP_POLL;
    {cmd_addr, cmd_data, cmd_len} = 24'h0;
    {ee_bus_if_i2.host_scl_val, ee_bus_if_i2.host_sda_val} = 2'b00;
    {ee_bus_if_i2.host_scl_en, ee_bus_if_i2.host_sda_en} = 2'b00;
    repeat (4) @(negedge clock);
    chk("rst_busy", busy, 8'h0);
    chk("rst_ptr", ptr, EE_PTR_RST);
    chk("rst_ready", cmd_ready, 8'h1);
    chk("rst_sda", ee_bus_if_i.sda, 8'h1);
    rst_n = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      cur = 8'hfe + i[7:0];
      run_cmd(EE_OP_WRITE, cur, 8'h0);
      chk("wr_nack", nack, 8'h0);
      chk("wr_ptr", ptr, {cur[7:3], cur[2:0] + 3'h1});
      run_cmd(EE_OP_POLL, 8'h0, 8'h0);
      chk("poll_busy", nack, 8'h1);
      for (k = 0; k < 8 && nack !== 1'b0; k++)
        run_cmd(EE_OP_POLL, 8'h0, 8'h0);
      chk("poll_ready", nack, 8'h0);
    end
    for (i = 0; i < 5; i++)
    begin
      if (rows[i].op == EE_OP_RAND_RD)
        cur = rows[i].a;
      run_cmd(rows[i].op, rows[i].a, rows[i].n);
      chk("rd_nack", nack, 8'h0);
      chk("rd_busy", busy, 8'h0);
      n = (rows[i].n == 8'h0) ? 1 : int'(rows[i].n);
      for (k = 0; k < n; k++)
        pop(val(cur + k[7:0]));
      chk("rd_empty", rd_valid, 8'h0);
      chk("rd_ptr", ptr, rows[i].p);
      cur = rows[i].p;
    end
    // Ten-byte read into the 8-word FIFO with the consumer stalled
    run_cmd(EE_OP_POLL, 8'h0, 8'h0);
    cmd_op = EE_OP_RAND_RD;
    cmd_addr = 8'hfe;
    cmd_len = 8'h0a;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    for (k = 0; k < 20000 && n < 300; k++)
    begin
      @(negedge clock);
      n = (ee_bus_if_i.scl === 1'b0) ? n + 1 : 0;
    end
    chk("stall_low", (n >= 300) ? 8'h1 : 8'h0, 8'h1);
    chk("stall_ready", cmd_ready, 8'h0);
    for (k = 0; k < 4; k++)
      pop(val(8'hfe + k[7:0]));
    rd_ready = 1'b1;
    n = 0;
    ack2 = 1'b0;
    for (k = 0; k < 20000 && !(ack2 && rd_valid !== 1'b1); k++)
    begin
      if (rd_valid === 1'b1)
        n++;
      if (done === 1'b1)
        ack2 = 1'b1;
      @(negedge clock);
    end
    rd_ready = 1'b0;
    chk("drain_done", ack2, 8'h1);
    chk("drain_cnt", n[7:0], 8'h06);
    chk("drain_ptr", ptr, 8'h08);
    // Faulty bench host: wrong code, then right code with a spike
    bb_frame(8'h90, -1, ack2);
    chk("bad_code", ack2, 8'h0);
    bb_frame(8'hae, 3, ack2);
    chk("spike_ack", ack2, 8'h1);
    chk("spike_ptr", ptr2, 8'h00);
    report_and_stop();
  end
endmodule // eeprom_read_and_ack_poll_tb
